// ===== include/ssf_pkg.sv
// package for the supply supervisor: register map, field layout, reset values, timing
// assumes a 50 MHz system clock and an APB master with 32-bit data
package ssf_pkg;
	localparam int unsigned CLK_HZ          = 50_000_000;
	// recovery hold after return to main supply, in microseconds
	localparam int unsigned REC_MIN_US      = 15_630;
	localparam int unsigned REC_MAX_US      = 31_250;
	// aim at the middle of the window; the result stays inside it
	localparam int unsigned REC_US          = (REC_MIN_US + REC_MAX_US) / 2;
	localparam int unsigned REC_CYCLES      = (CLK_HZ / 1_000_000) * REC_US;
	localparam int unsigned REC_W           = 21;

	localparam logic [7:0]  ADDR_CTRL       = 8'h00;
	localparam logic [7:0]  ADDR_STATUS     = 8'h04;
	localparam logic [7:0]  ADDR_CFG        = 8'h08;

	// control register fields
	localparam int unsigned CTRL_BATTERY_LOW_IRQ_ENABLE       = 0;
	localparam int unsigned CTRL_BIE        = 1;
	localparam int unsigned CTRL_TSE        = 2;
	localparam int unsigned CTRL_PM_LO      = 3;
	localparam int unsigned CTRL_PM_HI      = 5;
	// status register fields
	localparam int unsigned ST_BSF          = 0;
	localparam int unsigned ST_BLF          = 1;
	localparam int unsigned ST_OSF          = 2;
	localparam int unsigned ST_ONBAT        = 3;
	localparam int unsigned ST_PFO          = 4;
	localparam int unsigned ST_RST          = 5;
	// configuration register fields
	localparam int unsigned CFG_SQUARE_WAVE_OUTPUT      = 0;
	localparam int unsigned CFG_RESET_OVERRIDE        = 1;
	localparam int unsigned CFG_H24         = 2;

	localparam logic [2:0]  PM_DEFAULT      = 3'h0;
	localparam logic [2:0]  PM_STD_ALL      = 3'h0;
	localparam logic [2:0]  PM_STD_NOBL     = 3'h1;
	localparam logic [2:0]  PM_STD_NONE     = 3'h2;
	localparam logic [2:0]  PM_DIR_ALL      = 3'h3;
	localparam logic [2:0]  PM_DIR_NOBL     = 3'h4;
	localparam logic [2:0]  PM_DIR_NONE     = 3'h5;
	localparam logic [2:0]  PM_OFF_PF       = 3'h6;
	localparam logic [2:0]  PM_OFF_NONE     = 3'h7;
	localparam logic [2:0]  CFG_RESET       = 3'h7;
	localparam logic [31:0] RDATA_ZERO      = 32'h0000_0000;

	typedef enum logic [2:0] {
		PF_RUN = 3'b001,
		PF_BAT = 3'b010,
		PF_REC = 3'b100
	} ssf_pf_state_t;
endpackage

// ===== hdl/ssf_supervisor.sv
// supply supervisor: supply select, battery/osc flags, power-fail sequencing, apb registers
// assumes comparator and oscillator-stable inputs are asynchronous levels from analog cells
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
// Behaviour
// - direct mode: battery when main below battery
// - standard mode needs both; disabled selects main
// - switch flag zero while switch-over disabled
// - battery below threshold sets low flag
// - low monitoring continues on battery supply
// - low flag with enable raises interrupt
// - software cannot write low flag
// - low flag clears when battery recovers
// - active comparator below reference pulls output low
// - on battery: comparator off, output low
// - back on main: release, hold, re-enable
// - switch-over disabled: output follows comparator only
// - oscillator loss: internal reset, stop flag set
// - stop flag stays until software writes zero
// - reset held until oscillator reports stable
// - reset releases when oscillation resumes
// - after reset load documented defaults
// - power management field selects modes
// - switch to battery sets flag, irq, timestamp
// - switch flag cleared by software write or by switch-over disable
// - on battery ignore host, float interface (here only writes are ignored; reads are still answered)
module ssf_supervisor (
	input  wire logic        clk_i,
	input  wire logic        rstn_i,
	input  wire logic        main_lt_bat_i,
	input  wire logic        main_lt_swth_i,
	input  wire logic        bat_low_i,
	input  wire logic        pfi_below_ref_i,
	input  wire logic        osc_stable_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	input  wire logic [3:0]  pstrb_i,
	output logic             pready_o,
	output logic [31:0]      prdata_o,
	output logic             pslverr_o,
	output logic             backed_supply_out_o,
	output logic             battery_switch_flag_o,
	output logic             battery_low_flag_o,
	output logic             osc_stop_flag_o,
	output logic             battery_low_irq_o,
	output logic             battery_switch_irq_o,
	output logic             timestamp_capture_o,
	output logic             power_fail_out_n_o,
	output logic             power_fail_out_oe_o,
	output logic             pf_comp_enable_o,
	output logic             interface_oe_o,
	output logic             chip_reset_o,
	output logic             square_wave_output_en_o,
	output logic             reset_override_o,
	output logic             hour24_o
);
	import ssf_pkg::*;

	logic [4:0]        s1_q;
	logic [4:0]        s2_q;
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s1_q <= 5'h00;
			s2_q <= 5'h00;
		end else begin
			s1_q <= {osc_stable_i, pfi_below_ref_i, bat_low_i, main_lt_swth_i, main_lt_bat_i};
			s2_q <= s1_q;
		end
	end
	logic lt_bat, lt_sw, blow, pfi_lo, osc_ok;
	assign lt_bat = s2_q[0];
	assign lt_sw  = s2_q[1];
	assign blow   = s2_q[2];
	assign pfi_lo = s2_q[3];
	assign osc_ok = s2_q[4];

	logic [2:0]        pm_q;
	logic              battery_low_irq_enable_q;
	logic              bie_q;
	logic              tse_q;
	logic [2:0]        cfg_q;
	logic              bsf_q;
	logic              blf_q;
	logic              osf_q;
	logic              on_bat_q;
	logic              rst_q;
	logic              on_bat_d;
	logic              sw_off, direct, bl_en, pf_en;

	assign sw_off = (pm_q == PM_OFF_PF) || (pm_q == PM_OFF_NONE);
	assign direct = (pm_q == PM_DIR_ALL) || (pm_q == PM_DIR_NOBL) || (pm_q == PM_DIR_NONE);
	assign bl_en  = (pm_q == PM_STD_ALL) || (pm_q == PM_DIR_ALL);
	assign pf_en  = !((pm_q == PM_STD_NONE) || (pm_q == PM_DIR_NONE) || (pm_q == PM_OFF_NONE));

	always_comb begin
		if (sw_off) begin
			on_bat_d = 1'b0;
		end else if (direct) begin
			on_bat_d = lt_bat;
		end else begin
			on_bat_d = lt_bat && lt_sw;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rst_q <= 1'b1;
		end else begin
			rst_q <= !osc_ok;
		end
	end

	// apb: single-cycle access phase, writes ignored while on battery
	logic              wr_en, addr_ok;
	assign addr_ok = (paddr_i == ADDR_CTRL) || (paddr_i == ADDR_STATUS) || (paddr_i == ADDR_CFG);
	assign wr_en = psel_i && penable_i && pwrite_i && !on_bat_q && !rst_q && pstrb_i[0];

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pm_q   <= PM_DEFAULT;
			battery_low_irq_enable_q <= 1'b0;
			bie_q  <= 1'b0;
			tse_q  <= 1'b0;
			cfg_q  <= CFG_RESET;
		end else if (rst_q) begin
			pm_q   <= PM_DEFAULT;
			battery_low_irq_enable_q <= 1'b0;
			bie_q  <= 1'b0;
			tse_q  <= 1'b0;
			cfg_q  <= CFG_RESET;
		end else if (wr_en && paddr_i == ADDR_CTRL) begin
			battery_low_irq_enable_q <= pwdata_i[CTRL_BATTERY_LOW_IRQ_ENABLE];
			bie_q  <= pwdata_i[CTRL_BIE];
			tse_q  <= pwdata_i[CTRL_TSE];
			pm_q   <= pwdata_i[CTRL_PM_HI:CTRL_PM_LO];
		end else if (wr_en && paddr_i == ADDR_CFG) begin
			cfg_q  <= pwdata_i[CFG_H24:CFG_SQUARE_WAVE_OUTPUT];
		end
	end

	logic clr_bsf, clr_osf;
	assign clr_bsf = wr_en && (paddr_i == ADDR_STATUS) && !pwdata_i[ST_BSF];
	assign clr_osf = wr_en && (paddr_i == ADDR_STATUS) && !pwdata_i[ST_OSF];

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			on_bat_q <= 1'b0;
		end else begin
			on_bat_q <= on_bat_d;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			bsf_q <= 1'b0;
		end else if (sw_off) begin
			bsf_q <= 1'b0;
		end else if (on_bat_d && !on_bat_q) begin
			bsf_q <= 1'b1;
		end else if (clr_bsf) begin
			bsf_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			blf_q <= 1'b0;
		end else begin
			blf_q <= bl_en && blow;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			osf_q <= 1'b1;
		end else if (rst_q) begin
			osf_q <= 1'b1;
		end else if (clr_osf) begin
			osf_q <= 1'b0;
		end
	end

	// power-fail sequencer
	ssf_pf_state_t     pf_q;
	logic [REC_W-1:0]  rec_cnt_q;
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pf_q      <= PF_RUN;
			rec_cnt_q <= '0;
		end else begin
			unique case (pf_q)
				PF_RUN: begin
					if (on_bat_q && !sw_off) begin
						pf_q <= PF_BAT;
					end
				end
				PF_BAT: begin
					if (!on_bat_q) begin
						pf_q      <= PF_REC;
						rec_cnt_q <= REC_W'(REC_CYCLES - 1);
					end
				end
				PF_REC: begin
					if (on_bat_q) begin
						pf_q <= PF_BAT;
					end else if (sw_off) begin
						// no hold once switch-over is off
						pf_q <= PF_RUN;
					end else if (rec_cnt_q == '0) begin
						pf_q <= PF_RUN;
					end else begin
						rec_cnt_q <= rec_cnt_q - REC_W'(1);
					end
				end
			endcase
		end
	end

	// outputs, all registered
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			power_fail_out_n_o  <= 1'b0;
			power_fail_out_oe_o <= 1'b0;
			pf_comp_enable_o    <= 1'b1;
		end else begin
			pf_comp_enable_o <= (pf_q == PF_RUN) && pf_en;
			if (pf_q == PF_BAT) begin
				power_fail_out_oe_o <= 1'b1;
			end else if (pf_q == PF_REC) begin
				power_fail_out_oe_o <= 1'b0;
			end else begin
				power_fail_out_oe_o <= pf_en && pfi_lo;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			backed_supply_out_o     <= 1'b0;
			battery_switch_flag_o   <= 1'b0;
			battery_low_flag_o      <= 1'b0;
			osc_stop_flag_o         <= 1'b1;
			battery_low_irq_o       <= 1'b0;
			battery_switch_irq_o    <= 1'b0;
			timestamp_capture_o     <= 1'b0;
			interface_oe_o          <= 1'b0;
			chip_reset_o            <= 1'b1;
			square_wave_output_en_o <= 1'b1;
			reset_override_o        <= 1'b1;
			hour24_o                <= 1'b1;
		end else begin
			backed_supply_out_o     <= on_bat_q;
			battery_switch_flag_o   <= bsf_q;
			battery_low_flag_o      <= blf_q;
			osc_stop_flag_o         <= osf_q;
			battery_low_irq_o       <= blf_q && battery_low_irq_enable_q;
			battery_switch_irq_o    <= bsf_q && bie_q;
			timestamp_capture_o     <= tse_q && !sw_off && on_bat_d && !on_bat_q;
			interface_oe_o          <= !on_bat_d;
			chip_reset_o            <= rst_q;
			square_wave_output_en_o <= cfg_q[CFG_SQUARE_WAVE_OUTPUT];
			reset_override_o        <= cfg_q[CFG_RESET_OVERRIDE];
			hour24_o                <= cfg_q[CFG_H24];
		end
	end

	// read data registered in the setup cycle; pready high on every access phase
	logic [31:0] rd_d;
	always_comb begin
		rd_d = RDATA_ZERO;
		if (paddr_i == ADDR_CTRL) begin
			rd_d[CTRL_BATTERY_LOW_IRQ_ENABLE]              = battery_low_irq_enable_q;
			rd_d[CTRL_BIE]               = bie_q;
			rd_d[CTRL_TSE]               = tse_q;
			rd_d[CTRL_PM_HI:CTRL_PM_LO]  = pm_q;
		end else if (paddr_i == ADDR_STATUS) begin
			rd_d[ST_BSF]   = bsf_q;
			rd_d[ST_BLF]   = blf_q;
			rd_d[ST_OSF]   = osf_q;
			rd_d[ST_ONBAT] = on_bat_q;
			rd_d[ST_PFO]   = power_fail_out_oe_o;
			rd_d[ST_RST]   = rst_q;
		end else if (paddr_i == ADDR_CFG) begin
			rd_d[CFG_H24:CFG_SQUARE_WAVE_OUTPUT] = cfg_q;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pready_o  <= 1'b0;
			prdata_o  <= RDATA_ZERO;
			pslverr_o <= 1'b0;
		end else begin
			pready_o  <= psel_i && !penable_i;
			pslverr_o <= psel_i && !penable_i && !addr_ok;
			if (psel_i && !penable_i && !pwrite_i) begin
				prdata_o <= rd_d;
			end
		end
	end
endmodule

// ===== verif/ssf_analog_model.sv
// analog front end model: voltages in millivolts become comparator levels
// assumes the bench changes the voltages right after a rising clock edge
`timescale 1ns/1ps
module ssf_analog_model #(
	parameter int SW_TH_MV  = 2500,
	parameter int BAT_LO_MV = 2500,
	parameter int PF_REF_MV = 1250
) (
	input  wire logic [15:0] main_mv_i,
	input  wire logic [15:0] bat_mv_i,
	input  wire logic [15:0] pfi_mv_i,
	input  wire logic        osc_run_i,
	output logic             main_lt_bat_o,
	output logic             main_lt_swth_o,
	output logic             bat_low_o,
	output logic             pfi_below_ref_o,
	output logic             osc_stable_o
);
	// plain levels; the supervisor must synchronise them itself
	assign main_lt_bat_o   = main_mv_i < bat_mv_i;
	assign main_lt_swth_o  = main_mv_i < SW_TH_MV;
	assign bat_low_o       = bat_mv_i < BAT_LO_MV;
	assign pfi_below_ref_o = pfi_mv_i < PF_REF_MV;
	assign osc_stable_o    = osc_run_i;
endmodule

// ===== verif/ssf_monitor.sv
// checker for the supply supervisor, sees only the top module ports
// assumes it is bound to ssf_supervisor from the bench top file
`timescale 1ns/1ps
module ssf_monitor (
	input wire logic       clk_i,
	input wire logic       rstn_i,
	input wire logic       osc_stable_i,
	input wire logic       psel_i,
	input wire logic       penable_i,
	input wire logic       pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic       pready_o,
	input wire logic       backed_supply_out_o,
	input wire logic       battery_switch_flag_o,
	input wire logic       battery_low_flag_o,
	input wire logic       osc_stop_flag_o,
	input wire logic       battery_low_irq_o,
	input wire logic       battery_switch_irq_o,
	input wire logic       power_fail_out_oe_o,
	input wire logic       pf_comp_enable_o,
	input wire logic       interface_oe_o,
	input wire logic       chip_reset_o
);
	import ssf_pkg::*;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	wire logic wr_st = psel_i && penable_i && pwrite_i && paddr_i == ADDR_STATUS;

	apb_ready_a: assert property (psel_i && !penable_i |=> pready_o)
		else $error("no ready in access cycle");
	pf_battery_a: assert property (
		$rose(backed_supply_out_o) |-> ##[0:2] power_fail_out_oe_o && !pf_comp_enable_o)
		else $error("power fail not pulled on battery");
	rec_hold_a: assert property (
		$fell(backed_supply_out_o) |-> ##[0:2] (!power_fail_out_oe_o && !pf_comp_enable_o)[*8])
		else $error("power fail not released on return");
	switch_flag_a: assert property ($rose(battery_switch_flag_o) |-> backed_supply_out_o)
		else $error("switch flag without battery");
	switch_irq_a: assert property (
		battery_switch_irq_o |-> battery_switch_flag_o || $past(battery_switch_flag_o))
		else $error("switch irq without flag");
	low_irq_a: assert property (
		$rose(battery_low_irq_o) |-> battery_low_flag_o || $past(battery_low_flag_o))
		else $error("low irq without flag");
	osc_loss_a: assert property (
		$fell(osc_stable_i) |-> ##[1:6] chip_reset_o && osc_stop_flag_o)
		else $error("no reset on oscillator loss");
	osc_hold_a: assert property ((chip_reset_o && !osc_stable_i)[*5] |=> chip_reset_o)
		else $error("reset left without oscillator");
	rst_release_a: assert property ($rose(osc_stable_i) ##1 osc_stable_i[*7] |=> !chip_reset_o)
		else $error("reset held with oscillator running");
	osf_clear_a: assert property (
		$fell(osc_stop_flag_o) |-> $past(wr_st) || $past(wr_st, 2) || $past(wr_st, 3))
		else $error("stop flag cleared without write");
	iface_off_a: assert property ($rose(backed_supply_out_o) |-> ##[0:2] !interface_oe_o)
		else $error("interface still driven on battery");
endmodule

// ===== verif/tb_top.sv
// self-checking bench for the supply supervisor: apb driver, read notes, analog model
// assumes the recovery hold is far longer than the run, so it is only seen starting
`timescale 1ns/1ps
module tb_top;
	import ssf_pkg::*;
	typedef struct {logic [31:0] m; logic [31:0] v; logic e;} ssf_note_t;
	logic        clk_i = 1'b0, rstn_i = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
	logic        osc_run = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [3:0]  pstrb = 4'hf;
	logic [31:0] pwdata = 32'h0000_0000, prdata;
	logic [15:0] main_mv = 16'(3300), bat_mv = 16'(3000), pfi_mv = 16'(2000);
	logic        pready, pslverr, bso, lowirq, swirq, ifoe, lt_bat, lt_sw, blow, pfb, oscst;
	logic        tsc, pfon, sqw, reset_override, h24;
	int          errors = 0, checks = 0, ts_cnt = 0;
	ssf_note_t   notes[$];
	ssf_note_t   n;

	ssf_analog_model AFE (.main_mv_i(main_mv), .bat_mv_i(bat_mv), .pfi_mv_i(pfi_mv),
		.osc_run_i(osc_run), .main_lt_bat_o(lt_bat), .main_lt_swth_o(lt_sw),
		.bat_low_o(blow), .pfi_below_ref_o(pfb), .osc_stable_o(oscst));
	ssf_supervisor DUT (.clk_i(clk_i), .rstn_i(rstn_i), .main_lt_bat_i(lt_bat),
		.main_lt_swth_i(lt_sw), .bat_low_i(blow), .pfi_below_ref_i(pfb), .osc_stable_i(oscst),
		.psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
		.pstrb_i(pstrb), .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr),
		.backed_supply_out_o(bso), .battery_switch_flag_o(), .battery_low_flag_o(),
		.osc_stop_flag_o(), .battery_low_irq_o(lowirq), .battery_switch_irq_o(swirq),
		.timestamp_capture_o(tsc), .power_fail_out_n_o(pfon), .power_fail_out_oe_o(),
		.pf_comp_enable_o(), .interface_oe_o(ifoe), .chip_reset_o(),
		.square_wave_output_en_o(sqw), .reset_override_o(reset_override), .hour24_o(h24));

	initial forever #10 clk_i = ~clk_i;

	task automatic wt(input int c);
		repeat (c) @(posedge clk_i);
	endtask
	task automatic end_of_test;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t port %b expected %b", $time, got, exp);
		end
	endtask
	// reads leave a note; the watcher below compares when ready comes
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
			input logic [31:0] m, input logic [31:0] v);
		psel <= 1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= {3'($urandom), 1'b1};
		if (!w)
			notes.push_back('{m, v, a > ADDR_CFG});
		@(posedge clk_i);
		pen <= 1;
		// waits for the answer however long; only the watchdog ends a hang
		do @(posedge clk_i); while (pready !== 1'b1);
		psel <= 0;
		pen <= 0;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
		apb(1'b0, a, $urandom, m, v);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 0, 0);
	endtask
	// reserved upper bits get random junk, which must be ignored
	task automatic ctrl(input logic [2:0] pm, input logic [2:0] en);
		wr(ADDR_CTRL, ($urandom & 32'hffff_ffc0) | {26'h0, pm, en});
	endtask
	// two sync flops, select and flag stages: eight cycles covers them
	task automatic v(input int m, input int b, input int p);
		main_mv <= 16'(m);
		bat_mv <= 16'(b);
		pfi_mv <= 16'(p);
		wt(8);
	endtask

	always @(posedge clk_i) begin
		if (psel && pen && pready === 1'b1 && !pwr) begin
			n = notes.pop_front();
			checks++;
			if ((prdata & n.m) !== n.v || pslverr !== n.e) begin
				errors++;
				$display("[FAIL] %0t read %h gave %h", $time, paddr, prdata);
			end
		end
	end

	// capture is a one-cycle pulse, so it is counted rather than sampled later
	always @(posedge clk_i) begin
		if (tsc === 1'b1)
			ts_cnt++;
	end

	initial begin
		wt(20000);
		errors++;
		end_of_test;
	end

	initial begin
		void'($urandom(30388));
		wt(6);
		rstn_i <= 1;
		// host reads status first, with the oscillator still off
		rd(ADDR_STATUS, 32'h24, 32'h24);
		rd(ADDR_CFG, 32'h7, 32'h7);
		rd(ADDR_CTRL, 32'h38, 32'h0);
		chk(sqw, 1'b1);
		chk(reset_override, 1'b1);
		chk(h24, 1'b1);
		chk(pfon, 1'b0);
		osc_run <= 1;
		wt(8);
		rd(ADDR_STATUS, 32'h24, 32'h04);
		wr(ADDR_STATUS, 0);
		rd(ADDR_STATUS, 32'h24, 0);
		rd(8'(12 + 4 * ($urandom % 8)), 32'hffff_ffff, 0);
		for (int i = 7; i >= 0; i--) begin
			ctrl(3'(i), 3'b000);
			rd(ADDR_CTRL, 32'h38, 32'(i) << 3);
		end
		$display("reset and mode test done");
		v(3300, 3000, 1000);
		rd(ADDR_STATUS, 32'h18, 32'h10);
		ctrl(PM_STD_NONE, 0);
		rd(ADDR_STATUS, 32'h10, 0);
		ctrl(PM_OFF_PF, 0);
		v(2000, 3000, 1000);
		rd(ADDR_STATUS, 32'h19, 32'h10);
		v(2000, 3000, 2000);
		rd(ADDR_STATUS, 32'h19, 0);
		v(3300, 3000, 2000);
		$display("power fail test done");
		ctrl(PM_STD_ALL, 3'b011);
		v(2800, 3000, 2000);
		rd(ADDR_STATUS, 32'h08, 0);
		v(2000, 2800, 2000);
		rd(ADDR_STATUS, 32'h1b, 32'h19);
		chk(swirq, 1);
		chk(ifoe, 0);
		chk(ts_cnt == 0, 1'b1);
		wr(ADDR_CTRL, 0);
		v(2000, 2400, 2000);
		rd(ADDR_STATUS, 32'h02, 32'h02);
		chk(lowirq, 1);
		v(3300, 2400, 1000);
		rd(ADDR_STATUS, 32'h1b, 32'h03);
		rd(ADDR_CTRL, 32'h3f, 32'h03);
		wr(ADDR_STATUS, 32'hffff_fffd);
		rd(ADDR_STATUS, 32'h03, 32'h03);
		wr(ADDR_STATUS, 32'h0000_0004);
		rd(ADDR_STATUS, 32'h01, 0);
		chk(swirq, 0);
		v(3300, 3000, 1000);
		rd(ADDR_STATUS, 32'h12, 0);
		ctrl(PM_OFF_PF, 0);
		wt(2);
		rd(ADDR_STATUS, 32'h10, 32'h10);
		$display("battery test done");
		ctrl(PM_DIR_ALL, 3'b100);
		v(2800, 3000, 2000);
		rd(ADDR_STATUS, 32'h09, 32'h09);
		chk(ts_cnt == 1, 1'b1);
		v(3300, 3000, 2000);
		osc_run <= 0;
		wt(8);
		rd(ADDR_STATUS, 32'h24, 32'h24);
		wr(ADDR_STATUS, 0);
		osc_run <= 1;
		wt(8);
		rd(ADDR_STATUS, 32'h24, 32'h04);
		$display("direct and oscillator test done");
		end_of_test;
	end
endmodule

bind ssf_supervisor ssf_monitor MON (.clk_i(clk_i), .rstn_i(rstn_i),
	.osc_stable_i(osc_stable_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
	.paddr_i(paddr_i), .pready_o(pready_o), .backed_supply_out_o(backed_supply_out_o),
	.battery_switch_flag_o(battery_switch_flag_o), .battery_low_flag_o(battery_low_flag_o),
	.osc_stop_flag_o(osc_stop_flag_o), .battery_low_irq_o(battery_low_irq_o),
	.battery_switch_irq_o(battery_switch_irq_o), .power_fail_out_oe_o(power_fail_out_oe_o),
	.pf_comp_enable_o(pf_comp_enable_o), .interface_oe_o(interface_oe_o),
	.chip_reset_o(chip_reset_o));
